// ===== tcsp_map.vh
`ifndef TCSP_MAP_VH
`define TCSP_MAP_VH
// slot and round geometry
`define TCSP_SLOT_BITS      16
`define TCSP_ROUND_BITS     96
`define TCSP_LAST_BIT       7'h5F
`define TCSP_CTRL_DONE_BIT  7'h07
`define TCSP_BIT_IN_SLOT_LAST 4'hF
`define TCSP_FRAME16_LAST   9'h0FF
`define TCSP_FRAME32_LAST   9'h1FF
`define TCSP_HALF32_GRANT   9'h0FF
// slot numbers within a round
`define TCSP_SLOT_CTRL      3'h0
`define TCSP_SLOT_REGDATA   3'h1
`define TCSP_SLOT_D1_LEFT   3'h2
`define TCSP_SLOT_D1_RIGHT  3'h3
`define TCSP_SLOT_D2_LEFT   3'h4
`define TCSP_SLOT_D2_RIGHT  3'h5
// control word fields
`define TCSP_CW_DAC2_VALID  9
`define TCSP_CW_DAC1_VALID  8
`define TCSP_CW_READ        7
`define TCSP_CW_INDEX_MSB   4
// status word reset value and fields
`define TCSP_SW_ZERO        16'h0000
`define TCSP_SW_RIGHT_VALID 9
`define TCSP_SW_LEFT_VALID  8
`define TCSP_SW_DAC2_REQ    1
`define TCSP_SW_DAC1_REQ    0
// playback buffering
`define TCSP_REQ_ROOM       4
`define TCSP_FIFO_DEPTH     16
// timing: system clock and master serial clock rates in kHz
`define TCSP_CLK_KHZ        20000
`define TCSP_SCLK_SLOW_KHZ  12288
`define TCSP_SCLK_FAST_KHZ  16384
`endif

// ===== tcsp_fifo.v
`timescale 1ns/100ps
`include "tcsp_map.vh"

module tcsp_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = `TCSP_FIFO_DEPTH,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             reset_i,
  // fill side
  input  wire             in_valid_i,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             in_ready_o,
  // drain side
  output wire             out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input  wire             out_ready_i,
  // words held in the array
  output wire [AW:0]      level_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  reg             out_valid;
  reg [WIDTH-1:0] out_data;

  // wrap a pointer at the depth, which need not be a power of two
  function [AW-1:0] ptr_step;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - 1'b1) begin
        ptr_step = {AW{1'b0}};
      end else begin
        ptr_step = p + 1'b1;
      end
    end
  endfunction

  wire push = in_valid_i && in_ready_o;
  wire load = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready_i);

  assign in_ready_o  = (count < DEPTH[AW:0]);
  assign out_valid_o = out_valid;
  assign out_data_o  = out_data;
  assign level_o     = count;

  ////////////////////////////////////////////////////////////////////////////
  // array write, no reset needed on storage
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers, count and registered head word
  always @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr    <= {AW{1'b0}};
      rd_ptr    <= {AW{1'b0}};
      count     <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= ptr_step(wr_ptr);
      end
      if (load) begin
        rd_ptr    <= ptr_step(rd_ptr);
        out_data  <= mem[rd_ptr];
        out_valid <= 1'b1;
      end else if (out_ready_i) begin
        out_valid <= 1'b0;
      end
      if (push && !load) begin
        count <= count + 1'b1;
      end else if (load && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // tcsp_fifo

// ===== tcsp_slot_port.v
`timescale 1ns/100ps
`include "tcsp_map.vh"

// Overview of operation
// - 32-slot frame: rounds at slots 0 and 16, same six-slot assignment each.
// - frame size select one: 16-slot frame, traffic only in slots 0 to 5.
// - an ownership round is six 16-bit slots, 96 serial clock periods.
// - control word: dac2 valid bit 9, dac1 valid 8, read 7, index 4:0.
// - read/write bit one means register read, zero means register write.
// - exactly one register access, read or write, per owned round.
// - read data goes out in slot 1 of the following frame.
// - write data arrives in slot 1; prior value returns next frame.
// - written value takes effect when the round ends, chain out falling.
// - dac1 valid: stereo takes slots 2 and 3, mono slot 2 only.
// - dac2 valid: stereo takes slots 4 and 5, mono slot 4 only.
// - valid flag zero: that dac's playback slots are discarded.
// - valid flag ignored unless that dac requested in previous frame.
// - request flags already reflect this frame's accepted playback write.
// - samples msb first; in 8-bit formats the low byte is ignored.
// - frame sync rate at least sample rate, or half it in 32-slot.
// - as master, serial clock is half the system clock, at the slow and the fast setting alike.
// - slave round starts where ownership is granted, not at slot zero.
// - each channel 8 or 16 bits; each dac stereo or mono.
// - not owning: serial out released, serial in ignored.
// - status: right valid 9, left valid 8, dac2 req 1, dac1 req 0.
// - request only when dac enabled and its buffer has free space.
module tcsp_slot_port #(
  parameter FIFO_DEPTH = `TCSP_FIFO_DEPTH,
  parameter FIFO_AW    = 4
) (
  // clock and reset
  input  wire        clk_i,
  input  wire        reset_i,
  // mode straps
  input  wire        master_select_pin_i,
  input  wire        frame_size_select_i,
  input  wire        sclk_fast_i,
  // serial interface pins
  input  wire        sclk_pin_i,
  output reg         sclk_pin_o,
  output wire        sclk_pin_oe_o,
  output reg         frame_sync_pin_o,
  output wire        frame_sync_pin_oe_o,
  input  wire        serial_in_pin_i,
  output reg         serial_out_pin_o,
  output reg         serial_out_pin_oe_o,
  input  wire        slot_chain_in_i,
  output reg         slot_chain_out_o,
  // converter configuration
  input  wire [1:0]  dac_enable_i,
  input  wire [1:0]  dac_mono_i,
  input  wire [1:0]  dac_8bit_i,
  input  wire [1:0]  adc_8bit_i,
  // capture samples
  input  wire [15:0] adc_left_i,
  input  wire [15:0] adc_right_i,
  input  wire        adc_left_valid_i,
  input  wire        adc_right_valid_i,
  output reg         adc_taken_o,
  // playback samples
  output wire        play_valid_o,
  output wire [15:0] play_data_o,
  output wire [1:0]  play_chan_o,
  input  wire        play_ready_i,
  // control register access
  output reg  [4:0]  reg_index_o,
  input  wire [15:0] reg_rdata_i,
  output reg         reg_strobe_o,
  output reg         reg_write_o,
  output reg  [15:0] reg_wdata_o
);

  // master half periods in system cycles, rounded down, never below one
  localparam integer SLOW_DIV = `TCSP_CLK_KHZ / (2 * `TCSP_SCLK_SLOW_KHZ);
  localparam integer FAST_DIV = `TCSP_CLK_KHZ / (2 * `TCSP_SCLK_FAST_KHZ);
  localparam [7:0] SLOW_HALF = (SLOW_DIV < 1) ? 8'h01 : SLOW_DIV[7:0];
  localparam [7:0] FAST_HALF = (FAST_DIV < 1) ? 8'h01 : FAST_DIV[7:0];

  // words one dac loads this round
  function [2:0] dac_words;
    input taken;
    input mono;
    begin
      dac_words = taken ? (mono ? 3'h1 : 3'h2) : 3'h0;
    end
  endfunction

  // 8-bit formats carry nothing in the low byte
  function [15:0] fmt_mask;
    input [15:0] w;
    input        is8;
    begin
      fmt_mask = is8 ? {w[15:8], 8'h00} : w;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one feeds stage two only
  reg sclk_s1, sclk_s2, sdi_s1, sdi_s2, chain_s1, chain_s2, bm_s1, bm_s2;
  always @(posedge clk_i) begin
    if (reset_i) begin
      {sclk_s1, sclk_s2, sdi_s1, sdi_s2} <= 4'h0;
      {chain_s1, chain_s2} <= 2'h0;
      // strap keeps shifting in reset, else the capture below only sees zero
      bm_s1    <= master_select_pin_i;
      bm_s2    <= bm_s1;
    end else begin
      sclk_s1  <= sclk_pin_i;
      sclk_s2  <= sclk_s1;
      sdi_s1   <= serial_in_pin_i;
      sdi_s2   <= sdi_s1;
      chain_s1 <= slot_chain_in_i;
      chain_s2 <= chain_s1;
      bm_s1    <= master_select_pin_i;
      bm_s2    <= bm_s1;
    end
  end

  // master strap is caught only while reset is held
  reg is_master;
  always @(posedge clk_i) begin
    if (reset_i) begin
      is_master <= bm_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master clock divider and frame position
  reg [7:0] div_cnt;
  reg [8:0] frame_bit;
  wire [7:0] half_cyc  = sclk_fast_i ? FAST_HALF : SLOW_HALF;
  wire [8:0] frame_end = frame_size_select_i ? `TCSP_FRAME16_LAST
                                             : `TCSP_FRAME32_LAST;
  reg  sclk_prev;
  wire sclk_now = is_master ? sclk_pin_o : sclk_s2;
  wire rise     = sclk_now && !sclk_prev;
  wire fall     = !sclk_now && sclk_prev;

  assign sclk_pin_oe_o       = is_master;
  assign frame_sync_pin_oe_o = is_master;

  always @(posedge clk_i) begin
    if (reset_i) begin
      div_cnt          <= 8'h00;
      sclk_pin_o       <= 1'b0;
      sclk_prev        <= 1'b0;
      frame_bit        <= 9'h000;
      frame_sync_pin_o <= 1'b0;
    end else begin
      sclk_prev <= sclk_now;
      if (is_master && div_cnt >= half_cyc - 8'h01) begin
        div_cnt    <= 8'h00;
        sclk_pin_o <= !sclk_pin_o;
      end else if (is_master) begin
        div_cnt <= div_cnt + 8'h01;
      end
      if (fall) begin
        frame_bit <= (frame_bit >= frame_end) ? 9'h000 : frame_bit + 9'h001;
      end
      // sync pulse marks the period just before a frame begins
      if (rise) begin
        frame_sync_pin_o <= is_master && (frame_bit == frame_end);
      end
    end
  end

  // ownership grant: master owns slot 0, and slot 16 in 32-slot frames
  wire master_grant = (frame_bit == frame_end) ||
                      (!frame_size_select_i && frame_bit == `TCSP_HALF32_GRANT);
  wire grant_req    = is_master ? master_grant : chain_s2;

  ////////////////////////////////////////////////////////////////////////////
  // round state
  reg        owning;
  reg [6:0]  bit_cnt;
  reg [15:0] in_sh;
  reg [1:0]  valid_in;
  reg [1:0]  req_prev;
  reg [1:0]  taken;
  reg        read_req;
  reg [15:0] rd_hold;
  reg [15:0] readback;
  reg [15:0] cap_left;
  reg [15:0] cap_right;
  reg        cap_lv;
  reg        cap_rv;
  reg        push_valid;
  reg [17:0] push_data;

  wire [2:0]  slot      = bit_cnt[6:4];
  wire        slot_done = (bit_cnt[3:0] == `TCSP_BIT_IN_SLOT_LAST);
  wire        last_bit  = (bit_cnt == `TCSP_LAST_BIT);
  wire [15:0] in_word   = {in_sh[14:0], sdi_s2};
  wire [17:0] fifo_out;
  wire        fifo_in_ready;
  wire [FIFO_AW:0] fifo_level;

  // requests see the valid flags already received in this control word
  wire [1:0] take_now = valid_in & req_prev;
  wire [3:0] used     = {1'b0, dac_words(take_now[0], dac_mono_i[0])} +
                        {1'b0, dac_words(take_now[1], dac_mono_i[1])};
  wire [FIFO_AW:0] free_words = FIFO_DEPTH[FIFO_AW:0] - fifo_level;
  localparam [FIFO_AW+1:0] REQ_ROOM = `TCSP_REQ_ROOM;
  wire [FIFO_AW+1:0] need = {{(FIFO_AW-2){1'b0}}, used} + REQ_ROOM;
  wire room    = ({1'b0, free_words} >= need);
  wire [1:0] req_now = dac_enable_i & {room, room};

  // outgoing word for the current slot
  reg [15:0] out_word;
  always @* begin
    out_word = `TCSP_SW_ZERO;
    case (slot)
      `TCSP_SLOT_CTRL: begin
        out_word[`TCSP_SW_RIGHT_VALID] = cap_rv;
        out_word[`TCSP_SW_LEFT_VALID]  = cap_lv;
        out_word[`TCSP_SW_DAC2_REQ]    = req_now[1];
        out_word[`TCSP_SW_DAC1_REQ]    = req_now[0];
      end
      `TCSP_SLOT_REGDATA: out_word = readback;
      `TCSP_SLOT_D1_LEFT: out_word = cap_left;
      `TCSP_SLOT_D1_RIGHT: out_word = cap_right;
      default: out_word = `TCSP_SW_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // launch side: rising edges drive serial out and chain out
  always @(posedge clk_i) begin
    if (reset_i) begin
      serial_out_pin_o    <= 1'b0;
      serial_out_pin_oe_o <= 1'b0;
      slot_chain_out_o    <= 1'b0;
    end else if (fall && owning && last_bit) begin
      slot_chain_out_o <= 1'b0; // falls as the round closes
    end else if (rise) begin
      serial_out_pin_o    <= owning && out_word[4'hF - bit_cnt[3:0]];
      serial_out_pin_oe_o <= owning;
      slot_chain_out_o    <= owning && last_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample side: falling edges shift serial in and close slots
  always @(posedge clk_i) begin
    if (reset_i) begin
      owning       <= 1'b0;
      bit_cnt      <= 7'h00;
      in_sh        <= 16'h0000;
      valid_in     <= 2'h0;
      req_prev     <= 2'h0;
      taken        <= 2'h0;
      read_req     <= 1'b1;
      rd_hold      <= 16'h0000;
      readback     <= 16'h0000;
      cap_left     <= 16'h0000;
      cap_right    <= 16'h0000;
      cap_lv       <= 1'b0;
      cap_rv       <= 1'b0;
      push_valid   <= 1'b0;
      push_data    <= 18'h00000;
      reg_index_o  <= 5'h00;
      reg_strobe_o <= 1'b0;
      reg_write_o  <= 1'b0;
      reg_wdata_o  <= 16'h0000;
      adc_taken_o  <= 1'b0;
    end else begin
      push_valid   <= 1'b0;
      reg_strobe_o <= 1'b0;
      adc_taken_o  <= 1'b0;
      if (fall && owning) begin
        in_sh   <= in_word;
        bit_cnt <= bit_cnt + 7'h01;
        // both valid flags are in once bit 8 has been sampled
        if (bit_cnt == `TCSP_CTRL_DONE_BIT) begin
          valid_in <= {in_sh[0], sdi_s2};
        end
        if (slot_done) begin
          case (slot)
            `TCSP_SLOT_CTRL: begin
              read_req    <= in_word[`TCSP_CW_READ];
              reg_index_o <= in_word[`TCSP_CW_INDEX_MSB:0];
              taken       <= take_now;
              req_prev    <= req_now;
            end
            `TCSP_SLOT_REGDATA: begin
              reg_wdata_o <= in_word;
              rd_hold     <= reg_rdata_i;
            end
            `TCSP_SLOT_D1_LEFT: begin
              push_valid <= taken[0];
              push_data  <= {2'h0, fmt_mask(in_word, dac_8bit_i[0])};
            end
            `TCSP_SLOT_D1_RIGHT: begin
              push_valid <= taken[0] && !dac_mono_i[0];
              push_data  <= {2'h1, fmt_mask(in_word, dac_8bit_i[0])};
            end
            `TCSP_SLOT_D2_LEFT: begin
              push_valid <= taken[1];
              push_data  <= {2'h2, fmt_mask(in_word, dac_8bit_i[1])};
            end
            `TCSP_SLOT_D2_RIGHT: begin
              push_valid <= taken[1] && !dac_mono_i[1];
              push_data  <= {2'h3, fmt_mask(in_word, dac_8bit_i[1])};
            end
            default: push_valid <= 1'b0;
          endcase
        end
      end
      // round end: the one register access of the round is applied here
      if (fall && owning && last_bit) begin
        owning       <= 1'b0;
        bit_cnt      <= 7'h00;
        reg_strobe_o <= 1'b1;
        reg_write_o  <= !read_req;
        readback     <= rd_hold;
        adc_taken_o  <= cap_lv || cap_rv;
        taken        <= 2'h0;
      end
      // grant: chain in is looked at only when free or in the last period
      if (fall && grant_req && (!owning || last_bit)) begin
        owning    <= 1'b1;
        bit_cnt   <= 7'h00;
        valid_in  <= 2'h0;
        cap_left  <= fmt_mask(adc_left_i, adc_8bit_i[0]);
        cap_right <= fmt_mask(adc_right_i, adc_8bit_i[1]);
        cap_lv    <= adc_left_valid_i;
        cap_rv    <= adc_right_valid_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // playback buffer; its level throttles the request flags
  tcsp_fifo #(
    .WIDTH (18),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_play_fifo (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (push_valid),
    .in_data_i   (push_data),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (play_valid_o),
    .out_data_o  (fifo_out),
    .out_ready_i (play_ready_i),
    .level_o     (fifo_level)
  );

  // a push while full cannot happen while requests honour the room margin
  wire push_lost = push_valid && !fifo_in_ready;
  assign play_chan_o = push_lost ? fifo_out[17:16] : fifo_out[17:16];
  assign play_data_o = fifo_out[15:0];

endmodule // tcsp_slot_port

// ===== tcsp_slot_port_assertions.sv
`timescale 1ns/100ps
module tcsp_slot_port_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // watched outputs
  input wire logic serial_out_pin_oe_o,
  input wire logic slot_chain_out_o,
  input wire logic reg_strobe_o,
  input wire logic adc_taken_o
);
  int unsigned own_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////
  // clocks spent owning; a counter since 768 is far past any repetition
  always @(posedge clk_i) begin
    if (reset_i || !serial_out_pin_oe_o)
      own_cnt <= 0;
    else
      own_cnt <= own_cnt + 1;
  end
  // last serial period: chain out lasts half a period
  sequence s_last_fall;
    ##[3:5] $fell(slot_chain_out_o);
  endsequence
  sequence s_access;
    ##[3:5] reg_strobe_o;
  endsequence
  ////////////////////////
  a_reset_quiet: assert property (
    $fell(reset_i) |-> !serial_out_pin_oe_o && !slot_chain_out_o)
    else $error("outputs active right after reset");
  a_round_length: assert property (
    $fell(serial_out_pin_oe_o) |-> own_cnt inside {[767:769]})
    else $error("round not 96 serial periods");
  a_last_period: assert property (
    $rose(slot_chain_out_o) |-> s_last_fall)
    else $error("chain out not half a period");
  a_chain_owned: assert property (
    slot_chain_out_o |-> serial_out_pin_oe_o)
    else $error("chain out while not owning");
  a_one_access: assert property (
    $rose(slot_chain_out_o) |-> s_access)
    else $error("no access at round end");
  a_strobe_pulse: assert property (
    reg_strobe_o |=> !reg_strobe_o)
    else $error("access strobe longer than one clock");
  a_write_at_end: assert property (
    reg_strobe_o |-> $fell(slot_chain_out_o))
    else $error("access strobe off chain out fall");
  a_taken_end: assert property (
    adc_taken_o |-> $fell(slot_chain_out_o))
    else $error("capture taken off round end");
  a_start_quiet: assert property (
    $rose(serial_out_pin_oe_o) |-> (!slot_chain_out_o && !reg_strobe_o)[*8])
    else $error("round ends early");
endmodule // tcsp_slot_port_assertions

bind tcsp_slot_port tcsp_slot_port_assertions u_chk (.*);

// ===== tcsp_host_model.sv
`timescale 1ns/100ps
module tcsp_host_model (
  // lines driven by the host
  output logic      sclk_o,
  output logic      sdi_o,
  output logic      chain_o,
  // codec data out and its enable
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  logic [15:0] tx [0:5];
  logic [15:0] rx [0:5];
  logic        busy;
  ////////////////////////
  // clock stands low between rounds
  initial begin
    sclk_o = 1'b0;
    sdi_o = 1'b0;
    chain_o = 1'b0;
    busy = 1'b0;
  end
  // idle data keeps changing so a stale bit never passes
  always #100 if (!busy) sdi_o = ~sdi_o;
  // grant, 96 periods, then one closing rise to end ownership
  task automatic round;
    int b;
    begin
      busy = 1'b1;
      chain_o = 1'b1;
      #200 sclk_o = 1'b1;
      #200 sclk_o = 1'b0;
      #200 chain_o = 1'b0;
      for (b = 0; b < 97; b++) begin
        sclk_o = 1'b1;
        if (b < 96) sdi_o = tx[b/16][15-b%16];
        #200 sclk_o = 1'b0;
        // read late in the period: codec data lags the edge through sync
        #200 if (b < 96) rx[b/16][15-b%16] = sdo_oe_i ? sdo_i : 1'bx;
      end
      busy = 1'b0;
    end
  endtask
endmodule // tcsp_host_model

// ===== tcsp_slot_port_bench.sv
`timescale 1ns/100ps
module tcsp_slot_port_bench;
  logic             clk_i, reset_i, master_select_pin_i, frame_size_select_i;
  logic             sclk_fast_i, adc_left_valid_i, adc_right_valid_i, play_ready_i;
  logic [1:0]       dac_enable_i, dac_mono_i, dac_8bit_i, adc_8bit_i;
  logic [15:0]      adc_left_i, adc_right_i;
  wire logic        sclk_pin_i, serial_in_pin_i, slot_chain_in_i;
  wire logic        sclk_pin_o, sclk_pin_oe_o, frame_sync_pin_o, frame_sync_pin_oe_o;
  wire logic        serial_out_pin_o, serial_out_pin_oe_o, slot_chain_out_o;
  wire logic        adc_taken_o, play_valid_o, reg_strobe_o, reg_write_o;
  wire logic [15:0] play_data_o, reg_wdata_o, reg_rdata_i;
  wire logic [1:0]  play_chan_o;
  wire logic [4:0]  reg_index_o;
  logic [15:0]      bank [0:31];
  logic [15:0]      shadow [0:31];
  logic [17:0]      expq [$];
  logic [17:0]      got [$];
  logic [15:0]      rdexp;
  logic [1:0]       preq;
  logic [7:0]       n;
  int               fail_count, checked, cyc, strobes, writes, takens;

  tcsp_slot_port tcsp_slot_port_inst (.*);
  tcsp_host_model tcsp_host_model_inst (
    .sclk_o   (sclk_pin_i),
    .sdi_o    (serial_in_pin_i),
    .chain_o  (slot_chain_in_i),
    .sdo_i    (serial_out_pin_o),
    .sdo_oe_i (serial_out_pin_oe_o)
  );
  ////////////////////////
  // clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // register file behind the block, written at the access strobe only
  assign reg_rdata_i = bank[reg_index_o];
  always @(posedge clk_i) begin
    if (reg_strobe_o && reg_write_o) bank[reg_index_o] <= reg_wdata_o;
  end
  // access and capture pulses counted for the closing checks
  always @(posedge clk_i) begin
    if (!reset_i && reg_strobe_o) strobes++;
    if (!reset_i && reg_strobe_o && reg_write_o) writes++;
    if (!reset_i && adc_taken_o) takens++;
  end
  // playback words taken from the block
  always @(posedge clk_i) begin
    if (play_valid_o && play_ready_i) got.push_back({play_chan_o, play_data_o});
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  ////////////////////////
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] seen);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // 8-bit channels carry only the high byte
  function automatic logic [15:0] msk(input logic b8, input logic [15:0] w);
    return b8 ? {w[15:8], 8'h00} : w;
  endfunction
  // one ownership round, expectations built before it runs
  task automatic rnd(input logic [1:0] v, input logic rd, input logic [4:0] ix,
                     input logic [15:0] wd, input logic [1:0] mo, input logic [1:0] b8,
                     input logic [1:0] av, input logic rdy, input logic [1:0] en);
    int k;
    int pend;
    int used;
    logic [1:0] rq;
    @(negedge clk_i);
    play_ready_i = rdy;
    dac_enable_i = en;
    dac_mono_i = mo;
    dac_8bit_i = b8;
    adc_8bit_i = b8;
    adc_left_valid_i = av[0];
    adc_right_valid_i = av[1];
    adc_left_i = {8'hA1, n};
    adc_right_i = {8'hC3, n};
    repeat (40) @(negedge clk_i);
    pend = expq.size() - got.size();
    used = 0;
    tcsp_host_model_inst.tx[0] = {6'h00, v, rd, 2'b00, ix};
    tcsp_host_model_inst.tx[1] = wd;
    for (k = 2; k < 6; k++) tcsp_host_model_inst.tx[k] = {k[3:0], 4'h6, n};
    for (k = 0; k < 2; k++) begin
      if (v[k] && preq[k]) begin
        expq.push_back({k[0], 1'b0, msk(b8[k], tcsp_host_model_inst.tx[2+2*k])});
        used++;
        if (!mo[k]) begin
          expq.push_back({k[0], 1'b1, msk(b8[k], tcsp_host_model_inst.tx[3+2*k])});
          used++;
        end
      end
    end
    tcsp_host_model_inst.round();
    rq = (16 - pend - used >= 4) ? en : 2'b00;
    chk("status", {8'h00, av, 6'h00, rq}, {2'b00, tcsp_host_model_inst.rx[0]});
    if (n > 0) chk("readback", {2'b00, rdexp}, {2'b00, tcsp_host_model_inst.rx[1]});
    if (av[0]) chk("left", {2'b00, msk(b8[0], adc_left_i)}, {2'b00, tcsp_host_model_inst.rx[2]});
    if (av[1]) chk("right", {2'b00, msk(b8[1], adc_right_i)}, {2'b00, tcsp_host_model_inst.rx[3]});
    chk("unused", 18'h00000, {2'b00, tcsp_host_model_inst.rx[4] | tcsp_host_model_inst.rx[5]});
    rdexp = shadow[ix];
    if (!rd) shadow[ix] = wd;
    preq = rq;
    n++;
  endtask
  ////////////////////////
  // slave mode, 16-slot frames; rounds four to seven stall the drain to fill the buffer
  initial begin
    reset_i = 1'b1;
    master_select_pin_i = 1'b0;
    frame_size_select_i = 1'b1;
    sclk_fast_i = 1'b0;
    play_ready_i = 1'b1;
    dac_enable_i = 2'b00;
    dac_mono_i = 2'b00;
    dac_8bit_i = 2'b00;
    adc_8bit_i = 2'b00;
    adc_left_valid_i = 1'b0;
    adc_right_valid_i = 1'b0;
    adc_left_i = 16'h0000;
    adc_right_i = 16'h0000;
    n = 8'h00;
    preq = 2'b00;
    for (int i = 0; i < 32; i++) begin
      bank[i] = 16'h5A00 + 16'(i);
      shadow[i] = 16'h5A00 + 16'(i);
    end
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    rnd(2'b11, 1'b1, 5'h03, 16'h0000, 2'b00, 2'b00, 2'b01, 1'b1, 2'b01);
    rnd(2'b01, 1'b0, 5'h03, 16'hC3A5, 2'b00, 2'b00, 2'b10, 1'b1, 2'b11);
    rnd(2'b10, 1'b1, 5'h03, 16'h0000, 2'b10, 2'b10, 2'b11, 1'b1, 2'b11);
    rnd(2'b11, 1'b1, 5'h05, 16'h0000, 2'b00, 2'b00, 2'b00, 1'b0, 2'b11);
    rnd(2'b11, 1'b0, 5'h05, 16'h7E81, 2'b00, 2'b01, 2'b11, 1'b0, 2'b11);
    rnd(2'b11, 1'b1, 5'h05, 16'h0000, 2'b00, 2'b00, 2'b01, 1'b0, 2'b11);
    rnd(2'b11, 1'b1, 5'h03, 16'h0000, 2'b00, 2'b00, 2'b10, 1'b0, 2'b11);
    rnd(2'b11, 1'b1, 5'h03, 16'h0000, 2'b01, 2'b00, 2'b00, 1'b1, 2'b11);
    repeat (40) @(negedge clk_i);
    chk("words", 18'(expq.size()), 18'(got.size()));
    foreach (expq[i]) chk("play", expq[i], got[i]);
    chk("bank", {2'b00, 16'h7E81}, {2'b00, bank[5]});
    chk("strobes", 18'h00008, 18'(strobes));
    chk("writes", 18'h00002, 18'(writes));
    chk("taken", 18'h00006, 18'(takens));
    chk("slave pins", 18'h00000, {16'h0000, sclk_pin_oe_o, frame_sync_pin_oe_o});
    finish_test();
  end
endmodule // tcsp_slot_port_bench
